// *** common/pic_pkg.sv ***
package pic_pkg;
   localparam int NUM_SRC = 20;
   localparam logic [6:0] VEC_NMI = 7'h07;
   localparam logic [6:0] VEC_BASE = 7'h48;
   localparam logic [15:0] VADDR_STEP = 16'h0004;
   localparam logic [2:0] LVL_NMI = 3'h7;
   localparam logic [2:0] LVL_RESET = 3'h7;
   localparam int IDX_CH0 = 8;
   localparam int IDX_CH1 = 12;
   localparam int IDX_RSV_HI = 16;
   localparam logic [1:0] MODE_ZERO = 2'h0;
   localparam logic [1:0] MODE_TWO = 2'h2;
   localparam logic [3:0] DTC_MASK = 4'h6;
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_GRP_J = 8'h04;
   localparam logic [7:0] REG_GRP_K = 8'h08;
   localparam logic [7:0] REG_ENABLE = 8'h0c;
   localparam logic [7:0] REG_PEND = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_MASK = 8'h18;
   localparam logic [7:0] REG_LAST = 8'h1c;
   typedef enum logic [0:0] {
      PIC_IDLE = 1'b0,
      PIC_WAIT = 1'b1
   } pic_state_t;
   typedef struct packed {
      logic [6:0] vec;
      logic [15:0] vaddr;
      logic [2:0] lvl;
      logic nmi;
      logic data_transfer_controller;
   } pic_accept_t;
endpackage : pic_pkg

// *** hdl/pic_ctrl.sv ***
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// Functional notes
// - Non-maskable request accepted always, except during reset or hardware standby.
// - Every pin and peripheral source except the non-maskable pin has an enable bit gating it.
// - Mode field: 00 is mode 0, 10 is mode 2; low bit never set.
// - Mode 0: mask bit 1 leaves only the non-maskable request eligible.
// - Mode 2: each source group has a three-bit level, eight levels.
// - Mode 2: highest level wins, only when strictly above mask level.
// - Mode 2: single mask bit plays no part in gating.
// - Equal levels resolved by fixed vector-table order; vector number produced.
// - Losing requests stay pending until they win later.
// - Mode 2 acceptance forces the single mask bit to one.
// - Vector address is lower 16 bits of the handler pointer location.
// - Channel 0 uses vectors 80 to 83 from address 0140.
// - Channel 1 uses vectors 84 to 87 from address 0150.
// - Mode 2 acceptance clears trace bit and loads mask level.
// - Mode 0 acceptance sets the single mask bit.
// - Exception handling begins only after the current instruction completes.
module pic_ctrl
   import pic_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic standby,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Request sources, from pins
   input wire logic nmi_pin,
   input wire logic [NUM_SRC-1:0] src_req,
   // CPU side
   input wire logic insn_end,
   input wire logic cpu_mask_bit,
   input wire logic [2:0] mask_level_field,
   output logic accept,
   output pic_accept_t acc,
   output logic set_mask_bit,
   output logic clr_trace,
   output logic load_level,
   output logic [2:0] new_level,
   output logic dtc_req,
   // Interrupt
   output logic irq
);
   logic rst1_q, rst_q;
   logic [1:0] nmi_s_q;
   logic [NUM_SRC-1:0] src1_q, src_q;
   logic nmi_prev_q, nmi_pend_q;
   logic [1:0] mode_q;
   logic [2:0] grp_j_q, grp_k_q;
   logic [NUM_SRC-1:0] en_q;
   logic [1:0] stat_q, mask_q;
   pic_state_t state_q;
   pic_accept_t held_q;
   logic [NUM_SRC-1:0] live;
   logic cand;
   logic [4:0] win;
   logic [2:0] win_lvl;
   logic nmi_edge, go, take, fire, stby;
   logic [1:0] stby_s_q;
   pic_accept_t pick;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst1_q <= 1'b1;
         rst_q <= rst1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         nmi_s_q <= 2'h0;
         src1_q <= '0;
         src_q <= '0;
      end else begin
         nmi_s_q <= {nmi_s_q[0], nmi_pin};
         src1_q <= src_req;
         src_q <= src1_q;
      end
   end

   // Standby pin is asynchronous
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         stby_s_q <= 2'h0;
      end else begin
         stby_s_q <= {stby_s_q[0], standby};
      end
   end
   assign stby = stby_s_q[1];

   // Non-maskable edge latched until taken into the wait state; standby clears it
   assign nmi_edge = nmi_s_q[1] & ~nmi_prev_q;
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         nmi_prev_q <= 1'b0;
      end else begin
         nmi_prev_q <= nmi_s_q[1];
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         nmi_pend_q <= 1'b0;
      end else begin
         if (stby) begin
            nmi_pend_q <= 1'b0;
         end else if (nmi_edge) begin
            nmi_pend_q <= 1'b1;
         end else if (take && pick.nmi) begin
            nmi_pend_q <= 1'b0;
         end
      end
   end

   // Enabled channel sources 8 to 15 stay live while held; all other sources read as zero
   always_comb begin
      live = src_q & en_q;
      live[IDX_CH0-1:0] = '0;
      live[NUM_SRC-1:IDX_RSV_HI] = '0;
   end

   // Lowest index has top default rank
   always_comb begin
      cand = 1'b0;
      win = '0;
      win_lvl = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         logic [2:0] l;
         l = (i < IDX_CH1) ? grp_j_q : grp_k_q;
         if (live[i] && (!cand || l > win_lvl)) begin
            cand = 1'b1;
            win = 5'(i);
            win_lvl = l;
         end
      end
   end

   always_comb begin
      pick = '0;
      go = 1'b0;
      if (nmi_pend_q && !stby) begin
         go = 1'b1;
         pick.nmi = 1'b1;
         pick.vec = VEC_NMI;
         pick.lvl = LVL_NMI;
      end else if (cand) begin
         if (mode_q == MODE_TWO) begin
            go = win_lvl > mask_level_field;
         end else begin
            go = !cpu_mask_bit;
         end
         pick.vec = VEC_BASE + 7'(win);
         pick.lvl = win_lvl;
         pick.data_transfer_controller = (win >= 5'(IDX_CH0)) && DTC_MASK[win[1:0]];
      end
      pick.vaddr = 16'(pick.vec) * VADDR_STEP;
   end

   // Skip the cycle in which accept is high, while the CPU updates its masks
   assign take = go && (state_q == PIC_IDLE) && !accept;
   assign fire = (state_q == PIC_WAIT) && insn_end;

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         state_q <= PIC_IDLE;
         held_q <= '0;
      end else begin
         case (state_q)
            PIC_IDLE: begin
               if (take) begin
                  held_q <= pick;
                  state_q <= PIC_WAIT;
               end
            end
            PIC_WAIT: begin
               if (insn_end) begin
                  state_q <= PIC_IDLE;
               end
            end
            default: state_q <= PIC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         accept <= 1'b0;
      end else begin
         accept <= fire;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         acc <= '0;
      end else begin
         acc <= held_q;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         set_mask_bit <= 1'b0;
      end else begin
         set_mask_bit <= fire;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         clr_trace <= 1'b0;
      end else begin
         clr_trace <= fire && mode_q == MODE_TWO;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         load_level <= 1'b0;
      end else begin
         load_level <= fire && mode_q == MODE_TWO;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         new_level <= '0;
      end else begin
         new_level <= held_q.nmi ? LVL_NMI : held_q.lvl;
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         dtc_req <= 1'b0;
      end else begin
         dtc_req <= fire && held_q.data_transfer_controller;
      end
   end

   // Mode register, low bit never stored
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         mode_q <= MODE_ZERO;
      end else if (wr && addr == REG_MODE) begin
         mode_q <= {wdata[1], 1'b0};
      end
   end

   // Registers
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         grp_j_q <= LVL_RESET;
         grp_k_q <= LVL_RESET;
         en_q <= '0;
         mask_q <= '0;
      end else if (wr) begin
         case (addr)
            REG_GRP_J: grp_j_q <= wdata[2:0];
            REG_GRP_K: grp_k_q <= wdata[2:0];
            REG_ENABLE: en_q <= wdata[NUM_SRC-1:0];
            REG_MASK: mask_q <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // Status bit 0: accept, bit 1: nmi accept
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~((wr && addr == REG_STATUS) ? wdata[1:0] : 2'h0))
                   | {accept & acc.nmi, accept};
      end
   end
   assign irq = |(stat_q & mask_q);

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            REG_MODE: rdata <= {30'h0, mode_q};
            REG_GRP_J: rdata <= {29'h0, grp_j_q};
            REG_GRP_K: rdata <= {29'h0, grp_k_q};
            REG_ENABLE: rdata <= {12'h0, en_q};
            REG_PEND: rdata <= {11'h0, nmi_pend_q, live};
            REG_STATUS: rdata <= {30'h0, stat_q};
            REG_MASK: rdata <= {30'h0, mask_q};
            REG_LAST: rdata <= {9'h0, held_q.vec, held_q.vaddr};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule : pic_ctrl

// *** tb/pic_cpu_model.sv ***
`timescale 1ns/100ps
module pic_cpu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // From controller
   input wire logic set_mask_bit,
   input wire logic load_level,
   input wire logic [2:0] new_level,
   // From bench
   input wire logic mbit_clr,
   input wire logic lvl_wr,
   input wire logic [2:0] lvl_val,
   // CPU state
   output logic insn_end,
   output logic mbit,
   output logic [2:0] lvl
);
   logic [1:0] cnt_q;
   initial begin
      cnt_q = 2'h0;
      insn_end = 1'b0;
      mbit = 1'b0;
      lvl = 3'h7;
   end
   // Instruction ends every fourth cycle
   always @(posedge clk) begin
      cnt_q <= rstn ? cnt_q + 2'h1 : 2'h0;
      insn_end <= rstn && cnt_q == 2'h3;
      if (mbit_clr) mbit <= 1'b0;
      if (set_mask_bit) mbit <= 1'b1;
      if (lvl_wr) lvl <= lvl_val;
      if (load_level) lvl <= new_level;
   end
endmodule : pic_cpu_model

// *** tb/pic_ctrl_sva.sv ***
`timescale 1ns/100ps
module pic_ctrl_sva
   import pic_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // CPU side
   input wire logic insn_end,
   input wire logic [2:0] mask_level_field,
   input wire logic accept,
   input wire pic_accept_t acc,
   input wire logic set_mask_bit,
   input wire logic clr_trace,
   input wire logic load_level,
   input wire logic [2:0] new_level,
   input wire logic dtc_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   insn_wait_a: assert property (accept |-> $past(insn_end))
      else $error("accept before insn end");
   mask_set_a: assert property (set_mask_bit == accept)
      else $error("mask bit set mismatch");
   vec_addr_a: assert property (accept |-> acc.vaddr == {7'h0, acc.vec, 2'h0})
      else $error("vector address wrong");
   rsv_vec_a: assert property (accept && !acc.nmi |-> acc.vec inside {[7'h50:7'h57]})
      else $error("vector out of channel range");
   dtc_src_a: assert property (dtc_req == (accept && !acc.nmi && ^acc.vec[1:0]))
      else $error("transfer request wrong");
   trace_clr_a: assert property (load_level |-> accept && clr_trace)
      else $error("trace clear missing");
   nmi_lvl_a: assert property (load_level && acc.nmi |-> new_level == 3'h7)
      else $error("nmi level wrong");
   lvl_cmp_a: assert property (load_level && !acc.nmi |-> new_level == acc.lvl
      && acc.lvl > mask_level_field)
      else $error("level not above mask");
   acc_gap_a: assert property (accept |=> !accept [*2])
      else $error("accepts too close");
   cover property (accept && acc.nmi);
   cover property (dtc_req);
   cover property (load_level && !acc.nmi);
endmodule : pic_ctrl_sva
bind pic_ctrl pic_ctrl_sva u_sva (.clk, .rstn, .insn_end, .mask_level_field, .accept, .acc,
   .set_mask_bit, .clr_trace, .load_level, .new_level, .dtc_req);

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb
   import pic_pkg::*;
;
   logic clk, rstn, standby, wr, rd, nmi_pin, insn_end, mbit, accept, set_mask_bit;
   logic clr_trace, load_level, dtc_req, irq, ok;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [19:0] src_req;
   logic [2:0] lvl, new_level;
   logic [3:0] flg;
   logic mbit_clr = 1'b0;
   logic lvl_wr = 1'b0;
   logic [2:0] lvl_val = 3'h7;
   pic_accept_t acc, got;
   int n_mismatch = 0;
   int cmp_count = 0;
   pic_ctrl u_dut (.clk, .rstn, .standby, .addr, .wdata, .wr, .rd, .rdata, .nmi_pin, .src_req,
      .insn_end, .cpu_mask_bit(mbit), .mask_level_field(lvl), .accept, .acc, .set_mask_bit,
      .clr_trace, .load_level, .new_level, .dtc_req, .irq);
   pic_cpu_model u_cpu (.clk, .rstn, .set_mask_bit, .load_level, .new_level, .mbit_clr,
      .lvl_wr, .lvl_val, .insn_end, .mbit, .lvl);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   // Waits for an acceptance other than a repeat of skip
   task automatic wacc(input logic [6:0] skip, input logic e);
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge clk);
         #1 ok = accept === 1'b1 && acc.vec !== skip;
      end
      got = acc;
      flg = {clr_trace, new_level};
      chk("accept", 32'(ok), 32'(e));
      if (e && !ok) stop_test();
   endtask : wacc
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      #1 chk("irq", 32'(irq), 32'(e));
   endtask : irq_is
   initial begin
      {rstn, standby, wr, rd, nmi_pin, addr, wdata, src_req} = '0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      src_req <= 20'h02201;
      wacc(7'h7f, 1'b0);
      wr_reg(REG_ENABLE, 32'h000fffff);
      wacc(7'h7f, 1'b1);
      chk("ch0", 32'({got.vec, got.vaddr, got.data_transfer_controller}), {8'h0, 7'h51, 16'h0144, 1'b1});
      src_req <= 20'h02001;
      wacc(7'h51, 1'b0);
      @(posedge clk);
      mbit_clr <= 1'b1;
      @(posedge clk);
      mbit_clr <= 1'b0;
      wacc(7'h51, 1'b1);
      chk("ch1", 32'({got.vec, got.vaddr, got.data_transfer_controller}), {8'h0, 7'h55, 16'h0154, 1'b1});
      src_req <= '0;
      $display("mode zero test done");
      wr_reg(REG_MODE, 32'h3);
      rd_reg(REG_MODE, d);
      chk("mode", d, 32'h2);
      rd_reg(8'h20, d);
      chk("unmapped", d, 32'h0);
      src_req <= 20'h00100;
      wacc(7'h7f, 1'b0);
      @(posedge clk);
      lvl_val <= 3'h6;
      lvl_wr <= 1'b1;
      @(posedge clk);
      lvl_wr <= 1'b0;
      wacc(7'h7f, 1'b1);
      chk("lvl", 32'({got.vec, got.vaddr, got.data_transfer_controller, flg}), {4'h0, 7'h50, 16'h0140, 5'h0f});
      src_req <= '0;
      standby <= 1'b1;
      nmi_pin <= 1'b1;
      wacc(7'h7f, 1'b0);
      {standby, nmi_pin} <= 2'h0;
      repeat (4) @(posedge clk);
      nmi_pin <= 1'b1;
      wacc(7'h7f, 1'b1);
      chk("nmi", 32'({got.nmi, got.vec, flg}), {20'h0, 1'b1, VEC_NMI, 1'b1, LVL_NMI});
      $display("mode two test done");
      wr_reg(REG_MASK, 32'h0);
      irq_is(1'b0);
      wr_reg(REG_MASK, 32'h3);
      irq_is(1'b1);
      rd_reg(REG_STATUS, d);
      chk("status", d, 32'h3);
      wr_reg(REG_STATUS, 32'h3);
      irq_is(1'b0);
      $display("interrupt test done");
      stop_test();
   end
endmodule : tb
